//--- hw/iobd_ctrl.sv
/*
  Device controller end of the byte-wide multiplexed I/O bus: select,
  command output, data and status input, interrupt attention and the
  daisy-chained acknowledge. Assumes a processor on the far side that
  keeps the strobe/reply handshake; all bus pins are active low and
  asynchronous to CLK_I.
*/
`timescale 1ns/1ns

module iobd_ctrl #(
  parameter logic [7:0] DEV_NUM = iobd_pkg::DEV_NUM_DEF
) (
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  input  wire logic [7:0] HOST_OUT_LINES_N_I,
  input  wire logic       SELECT_STROBE_N_I,
  input  wire logic       COMMAND_STROBE_N_I,
  input  wire logic       DATA_REQUEST_N_I,
  input  wire logic       STATUS_REQUEST_N_I,
  input  wire logic       CHAIN_GRANT_IN_N_I,
  input  wire logic       SYSTEM_CLEAR_N_I,
  input  wire logic       DEV_INTERRUPT_I,
  input  wire logic [7:0] DEV_DATA_I,
  input  wire logic [7:0] DEV_STATUS_I,
  output logic [7:0]      DEVICE_IN_LINES_N_O,
  output logic            HANDSHAKE_REPLY_N_O,
  output logic            ATTENTION_REQUEST_N_O,
  output logic            CHAIN_GRANT_OUT_N_O,
  output logic [7:0]      COMMAND_O,
  output logic            COMMAND_STB_O,
  output logic            SELECTED_O,
  output logic            INTERRUPT_PENDING_O
);

  typedef struct packed {
    logic [7:0]            host_s1;
    logic [7:0]            host_s2;
    logic [5:0]            ctl_s1;
    logic [5:0]            ctl_s2;
    logic                  irq_s1;
    logic                  irq_s2;
    logic                  irq_prev;
    logic                  selected;
    logic                  pending;
    logic [7:0]            command;
    logic                  cmd_stb;
    iobd_pkg::iobd_reply_t reply;
    logic [7:0]            din_n;
    logic                  reply_n;
    logic                  attn_n;
    logic                  gout_n;
  } iobd_state_t;

  iobd_state_t st;
  iobd_state_t next_st;

  // synchronised, active-high views of the bus controls
  logic sel_a, cmd_a, dreq_a, sreq_a, grant_a, clr_a;
  assign sel_a   = st.ctl_s2[0];
  assign cmd_a   = st.ctl_s2[1];
  assign dreq_a  = st.ctl_s2[2];
  assign sreq_a  = st.ctl_s2[3];
  assign grant_a = st.ctl_s2[4];
  assign clr_a   = st.ctl_s2[5];

  always_comb begin
    next_st = st;
    // two-flop synchronisers on every bus input
    next_st.host_s1 = ~HOST_OUT_LINES_N_I;
    next_st.host_s2 = st.host_s1;
    next_st.ctl_s1 = ~{SYSTEM_CLEAR_N_I, CHAIN_GRANT_IN_N_I, STATUS_REQUEST_N_I,
                       DATA_REQUEST_N_I, COMMAND_STROBE_N_I, SELECT_STROBE_N_I};
    next_st.ctl_s2 = st.ctl_s1;
    next_st.irq_s1 = DEV_INTERRUPT_I;
    next_st.irq_s2 = st.irq_s1;
    next_st.irq_prev = st.irq_s2;
    next_st.cmd_stb = 1'b0;

    // rising device interrupt sets pending; acknowledge and clear below override it
    if (st.irq_s2 && !st.irq_prev) begin
      next_st.pending = 1'b1;
    end

    unique case (st.reply)
      iobd_pkg::IOBD_IDLE: begin
        if (sel_a) begin
          next_st.selected = (st.host_s2 == DEV_NUM);
          if (st.host_s2 == DEV_NUM) begin
            next_st.reply = iobd_pkg::IOBD_SEL;
          end
        end else if (cmd_a && st.selected) begin
          next_st.command = st.host_s2;
          next_st.cmd_stb = 1'b1;
          next_st.reply   = iobd_pkg::IOBD_CMD;
        end else if (dreq_a && st.selected) begin
          next_st.din_n = ~DEV_DATA_I;
          next_st.reply = iobd_pkg::IOBD_DATA;
        end else if (sreq_a && st.selected) begin
          next_st.din_n = ~DEV_STATUS_I;
          next_st.reply = iobd_pkg::IOBD_STAT;
        end else if (grant_a && st.pending) begin
          next_st.din_n   = ~DEV_NUM;
          next_st.pending = 1'b0;
          next_st.reply   = iobd_pkg::IOBD_ACK;
        end
      end
      iobd_pkg::IOBD_SEL:  if (!sel_a)   next_st.reply = iobd_pkg::IOBD_IDLE;
      iobd_pkg::IOBD_CMD:  if (!cmd_a)   next_st.reply = iobd_pkg::IOBD_IDLE;
      iobd_pkg::IOBD_DATA: if (!dreq_a)  next_st.reply = iobd_pkg::IOBD_IDLE;
      iobd_pkg::IOBD_STAT: if (!sreq_a)  next_st.reply = iobd_pkg::IOBD_IDLE;
      iobd_pkg::IOBD_ACK:  if (!grant_a) next_st.reply = iobd_pkg::IOBD_IDLE;
      default:             next_st.reply = iobd_pkg::IOBD_IDLE;
    endcase

    if (next_st.reply == iobd_pkg::IOBD_IDLE || next_st.reply == iobd_pkg::IOBD_SEL
        || next_st.reply == iobd_pkg::IOBD_CMD) begin
      next_st.din_n = iobd_pkg::LINES_IDLE;
    end
    next_st.reply_n = (next_st.reply == iobd_pkg::IOBD_IDLE);
    // grant passes only when nothing pending and not being answered here
    next_st.gout_n = ~(grant_a && !st.pending
                       && st.reply != iobd_pkg::IOBD_ACK);

    if (clr_a) begin
      next_st.selected = 1'b0;
      next_st.pending  = 1'b0;
      next_st.command  = iobd_pkg::CMD_RESET;
      next_st.reply    = iobd_pkg::IOBD_IDLE;
      next_st.din_n    = iobd_pkg::LINES_IDLE;
      next_st.reply_n  = iobd_pkg::LINE_OFF;
      next_st.gout_n   = iobd_pkg::LINE_OFF;
    end
    // attention kept in its own flop so the pin comes straight from a register
    next_st.attn_n = ~next_st.pending;
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st          <= '0;
      st.command  <= iobd_pkg::CMD_RESET;
      st.reply    <= iobd_pkg::IOBD_IDLE;
      st.din_n    <= iobd_pkg::LINES_IDLE;
      st.reply_n  <= iobd_pkg::LINE_OFF;
      st.attn_n   <= iobd_pkg::LINE_OFF;
      st.gout_n   <= iobd_pkg::LINE_OFF;
    end else begin
      st <= next_st;
    end
  end

  assign DEVICE_IN_LINES_N_O   = st.din_n;
  assign HANDSHAKE_REPLY_N_O   = st.reply_n;
  assign ATTENTION_REQUEST_N_O = st.attn_n;
  assign CHAIN_GRANT_OUT_N_O   = st.gout_n;
  assign COMMAND_O             = st.command;
  assign COMMAND_STB_O         = st.cmd_stb;
  assign SELECTED_O            = st.selected;
  assign INTERRUPT_PENDING_O   = st.pending;

  a_cmd_reply: assert property (@(posedge CLK_I) disable iff (RST_I)
    (st.reply == iobd_pkg::IOBD_IDLE && cmd_a && !sel_a && st.selected && !clr_a)
    |=> (!HANDSHAKE_REPLY_N_O && COMMAND_STB_O))
    else $error("command strobe not answered");
  a_cmd_unsel: assert property (@(posedge CLK_I) disable iff (RST_I)
    (!st.selected && !sel_a) |=> !COMMAND_STB_O)
    else $error("command taken while unselected");
  a_cmd_store: assert property (@(posedge CLK_I) disable iff (RST_I)
    COMMAND_STB_O |-> COMMAND_O == $past(st.host_s2))
    else $error("command byte mismatch");
  a_reply_drop: assert property (@(posedge CLK_I) disable iff (RST_I)
    (st.reply == iobd_pkg::IOBD_CMD && !cmd_a) |=> HANDSHAKE_REPLY_N_O)
    else $error("reply held after strobe removed");
  a_atn_level: assert property (@(posedge CLK_I) disable iff (RST_I)
    (st.irq_s2 && !st.irq_prev && !clr_a && !(grant_a && st.pending))
    |=> !ATTENTION_REQUEST_N_O)
    else $error("attention not raised");
  a_chain_block: assert property (@(posedge CLK_I) disable iff (RST_I)
    st.pending |=> CHAIN_GRANT_OUT_N_O)
    else $error("grant passed while pending");
  a_chain_pass: assert property (@(posedge CLK_I) disable iff (RST_I)
    (grant_a && !st.pending && st.reply == iobd_pkg::IOBD_IDLE && !clr_a)
    |=> !CHAIN_GRANT_OUT_N_O)
    else $error("grant not passed");
  a_ack_number: assert property (@(posedge CLK_I) disable iff (RST_I)
    (st.reply == iobd_pkg::IOBD_IDLE && grant_a && st.pending && !sel_a && !cmd_a
     && !dreq_a && !sreq_a && !clr_a)
    |=> (DEVICE_IN_LINES_N_O == ~DEV_NUM && !HANDSHAKE_REPLY_N_O
         && ATTENTION_REQUEST_N_O))
    else $error("acknowledge answer wrong");
  a_ack_release: assert property (@(posedge CLK_I) disable iff (RST_I)
    (st.reply == iobd_pkg::IOBD_ACK && !grant_a)
    |=> (HANDSHAKE_REPLY_N_O && DEVICE_IN_LINES_N_O == iobd_pkg::LINES_IDLE))
    else $error("acknowledge not released");
  a_clear_desel: assert property (@(posedge CLK_I) disable iff (RST_I)
    clr_a |=> !SELECTED_O)
    else $error("clear left device selected");

  c_cmd:  cover property (@(posedge CLK_I) disable iff (RST_I) COMMAND_STB_O);
  c_ack:  cover property (@(posedge CLK_I) disable iff (RST_I) st.reply == iobd_pkg::IOBD_ACK);
  c_stat: cover property (@(posedge CLK_I) disable iff (RST_I) st.reply == iobd_pkg::IOBD_STAT);
  c_pass: cover property (@(posedge CLK_I) disable iff (RST_I) !CHAIN_GRANT_OUT_N_O);

endmodule

//--- hw/iobd_pkg.sv
/*
  Package for the I/O bus device controller: widths, idle levels and
  the reply state encoding. Assumes all bus lines are active low.
*/
package iobd_pkg;
  localparam int          BYTE_W      = 8;
  localparam logic [7:0]  CMD_RESET   = 8'h00;
  localparam logic [7:0]  DEV_NUM_DEF = 8'h22;  // arbitrary default device number
  localparam logic [7:0]  LINES_IDLE  = 8'hFF;  // released active-low byte lanes
  localparam logic        LINE_OFF    = 1'b1;   // released active-low control line

  typedef enum logic [2:0] {
    IOBD_IDLE   = 3'b000,
    IOBD_SEL    = 3'b001,
    IOBD_CMD    = 3'b010,
    IOBD_DATA   = 3'b011,
    IOBD_STAT   = 3'b100,
    IOBD_ACK    = 3'b101
  } iobd_reply_t;
endpackage

//--- sim/iobd_proc.sv
/*
  Processor model for the multiplexed I/O bus: strobe/reply handshakes.
  Assumes active-low lines and a controller that answers on its clock.
*/
`timescale 1ns/1ns
module iobd_proc #(
  parameter int TO_CYC = 600  // reply limit, 60 us at 10 MHz
) (
  input  wire logic       clk_i,
  input  wire logic       reply_n_i,
  input  wire logic [7:0] lines_n_i,
  output logic [7:0]      host_n_o,
  output logic [4:0]      stb_n_o,
  output logic            timeout_o
);
  initial begin
    host_n_o  = 8'hFF;
    stb_n_o   = 5'h1F;
    timeout_o = 1'b0;
  end
  // kind: 0 select, 1 command, 2 data, 3 status, 4 grant
  task automatic hs(input int kind, input logic [7:0] b, output logic [7:0] rd);
    int n;
    n = 0;
    @(negedge clk_i);
    host_n_o = ~b;
    repeat (2) @(negedge clk_i);
    stb_n_o[kind] = 1'b0;
    while (reply_n_i !== 1'b0 && n < TO_CYC) begin
      @(negedge clk_i);
      n++;
    end
    timeout_o = (n >= TO_CYC);
    rd = ~lines_n_i;
    @(negedge clk_i);
    stb_n_o[kind] = 1'b1;
    host_n_o = 8'hFF;
    n = 0;
    while (reply_n_i !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
  endtask
endmodule

//--- sim/testbench.sv
/*
  Self-checking bench for the I/O bus device controller.
  Assumes the processor model in iobd_proc and a 10 MHz clock.
*/
`timescale 1ns/1ns
module testbench;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       clr_n = 1'b1;
  logic       irq = 1'b0;
  logic [7:0] ddata = 8'h00;
  logic [7:0] dstat = 8'h00;
  logic [7:0] host_n, lines_n, cmd, rd, b;
  logic [4:0] stb_n;
  logic       reply_n, attn_n, gout_n, cmd_stb, sel, pend, to;
  int         num_errors = 0;
  int         n_checks = 0;
  int         n_stb = 0;
  always #50 clk = ~clk;
  always @(negedge clk) if (cmd_stb === 1'b1) n_stb++;
  iobd_proc proc_u (.clk_i(clk), .reply_n_i(reply_n), .lines_n_i(lines_n),
    .host_n_o(host_n), .stb_n_o(stb_n), .timeout_o(to));
  iobd_ctrl dut_u (.CLK_I(clk), .RST_I(rst), .HOST_OUT_LINES_N_I(host_n),
    .SELECT_STROBE_N_I(stb_n[0]), .COMMAND_STROBE_N_I(stb_n[1]),
    .DATA_REQUEST_N_I(stb_n[2]), .STATUS_REQUEST_N_I(stb_n[3]),
    .CHAIN_GRANT_IN_N_I(stb_n[4]), .SYSTEM_CLEAR_N_I(clr_n), .DEV_INTERRUPT_I(irq),
    .DEV_DATA_I(ddata), .DEV_STATUS_I(dstat), .DEVICE_IN_LINES_N_O(lines_n),
    .HANDSHAKE_REPLY_N_O(reply_n), .ATTENTION_REQUEST_N_O(attn_n),
    .CHAIN_GRANT_OUT_N_O(gout_n), .COMMAND_O(cmd), .COMMAND_STB_O(cmd_stb),
    .SELECTED_O(sel), .INTERRUPT_PENDING_O(pend));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic endt(input string s);
    $display("test %s done, mismatches so far %0d", s, num_errors);
  endtask
  // condition code is the low three status bits; the fourth from the bottom is busy
  function automatic logic stat_busy(input logic [7:0] s);
    return s[3];
  endfunction
  function automatic logic stat_abort(input logic [7:0] s);
    return |s[2:0];
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #(20000 * 100);
    num_errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(26580));
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk({reply_n, attn_n, gout_n, sel, pend, 3'h0}, 8'hE0, "reset flags");
    chk(lines_n, 8'hFF, "reset lines");
    chk(cmd, 8'h00, "reset command");
    endt("reset");
    proc_u.hs(1, 8'h5A, rd);
    chk({7'h00, to}, 8'h01, "unselected command timeout");
    chk(cmd, 8'h00, "unselected command");
    proc_u.hs(0, iobd_pkg::DEV_NUM_DEF, rd);
    chk({7'h00, sel}, 8'h01, "selected");
    for (int i = 0; i < 6; i++) begin
      b = (i == 0) ? 8'hFF : 8'($urandom);
      proc_u.hs(1, b, rd);
      chk(cmd, b, "command");
      chk({7'h00, reply_n}, 8'h01, "reply off");
    end
    chk(8'(n_stb), 8'h06, "command pulses");
    endt("command");
    for (int a = 0; a < 8; a++) begin
      ddata = 8'($urandom);
      proc_u.hs(2, 8'hFF, rd);
      chk(rd, ddata, "data byte");
      do begin
        dstat = 8'($urandom) & ((a < 6) ? 8'hF8 : 8'hFF);
        proc_u.hs(3, 8'hFF, rd);
        chk(rd, dstat, "status byte");
      end while (stat_busy(rd) !== 1'b0);
      if (stat_abort(rd) !== 1'b0) break;
    end
    endt("block read");
    proc_u.hs(0, ~iobd_pkg::DEV_NUM_DEF, rd);
    chk({7'h00, sel}, 8'h00, "deselected");
    chk({7'h00, to}, 8'h01, "no reply to other number");
    fork
      proc_u.hs(4, 8'hFF, rd);
      begin repeat (9) @(negedge clk); chk({7'h00, gout_n}, 8'h00, "grant passed"); end
    join
    chk({7'h00, to}, 8'h01, "no reply to passed grant");
    irq = 1'b1;
    repeat (5) @(negedge clk);
    chk({6'h00, attn_n, pend}, 8'h01, "attention");
    fork
      proc_u.hs(4, 8'hFF, rd);
      begin repeat (7) @(negedge clk); chk({7'h00, gout_n}, 8'h01, "grant held"); end
    join
    chk(rd, iobd_pkg::DEV_NUM_DEF, "device number");
    chk({6'h00, attn_n, pend}, 8'h02, "attention off");
    chk(lines_n, 8'hFF, "lines released");
    chk({7'h00, reply_n}, 8'h01, "reply released");
    irq = 1'b0;
    proc_u.hs(0, iobd_pkg::DEV_NUM_DEF, rd);
    dstat = 8'($urandom);
    proc_u.hs(3, 8'hFF, rd);
    chk(rd, dstat, "status after acknowledge");
    endt("interrupt");
    irq = 1'b1;
    repeat (5) @(negedge clk);
    chk({6'h00, attn_n, pend}, 8'h01, "attention before clear");
    clr_n = 1'b0;
    repeat (4) @(negedge clk);
    clr_n = 1'b1;
    chk({7'h00, sel}, 8'h00, "clear deselects");
    chk(cmd, 8'h00, "clear command");
    chk({6'h00, attn_n, pend}, 8'h02, "clear pending");
    endt("clear");
    report_and_stop();
  end
endmodule
